// [rtl/fpx_exc_unit.sv]
// fpx_exc_unit: operand error and overflow detection, flags, qnan substitution, exception posting
// assumes: datapath presents one finished op per cycle on req, pipeline pulses fpStart per fp instr
//
// Function
// - operand error always sets operand error flag in exception status byte
// - add of opposite infinities or subtract of like infinities is operand error
// - zero times infinity, zero/zero, inf/inf, sqrt negative or infinite: operand error
// - maskable operand error, handler off: write quiet nan with sign clear and all other bits ones, no exception
// - maskable operand error, handler on: keep destination, post, pre-instruction take later
// - operand error exceptions vector through the operand error entry
// - move to integer overflow, nan, inf or most negative: immediate post-instruction exception
// - overflow when destination fp register, memory or integer register and exponent reaches precision maximum
// - overflow only for single, double, extended; other formats report operand error
// - check underflow, round, then check overflow, before storing destination
// - round to selected precision; overflow past that precision even if extended fits
// - overflow sets overflow flag in exception status byte
// - overflow flag set by an instruction always takes overflow exception
// - overflow into fp register leaves it unmodified, posted, pre-instruction take later
// - overflow into memory or integer register stores undefined, immediate post exception
`timescale 1ns/1ps

module fpx_exc_unit #(
  parameter logic [7:0] VEC_OPERAND_ERROR_FLAG = fpx_pkg::VEC_OPERAND_ERROR_FLAG_DEF,
  parameter logic [7:0] VEC_OVERFLOW_FLAG  = fpx_pkg::VEC_OVERFLOW_FLAG_DEF
) (
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output      logic              hreadyout,
  output      logic              hresp,
  output      logic [31:0]       hrdata,
  input  wire fpx_pkg::fpx_req_s req,
  input  wire logic              fpStart,
  output      fpx_pkg::fpx_dst_s dstCtl,
  output      fpx_pkg::fpx_exc_s exc,
  output      logic              irq
);
  import fpx_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic isIntFmt(input fpx_fmt_e f);
    return (f == FMT_BYTE) || (f == FMT_WORD) || (f == FMT_LONG);
  endfunction

  function automatic logic [EXP_W-1:0] precMax(input fpx_prec_e p);
    unique case (p)
      PREC_SGL: return EXP_MAX_SGL;
      PREC_DBL: return EXP_MAX_DBL;
      default:  return EXP_MAX_EXT;
    endcase
  endfunction

  function automatic fpx_prec_e fmtPrec(input fpx_fmt_e f);
    unique case (f)
      FMT_SGL: return PREC_SGL;
      FMT_DBL: return PREC_DBL;
      default: return PREC_EXT;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // bus slave: address phase capture
  // ----------------------------------------------------------------
  logic              wrPend_r, wrPend_nxt;
  logic [ADDR_W-1:0] wrAddr_r, wrAddr_nxt;
  logic [31:0]       rdData_r, rdData_nxt;
  logic [ST_W-1:0]   status_r, status_nxt;
  logic [ST_W-1:0]   mask_r, mask_nxt;
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
  fpx_pend_e         pend_r, pend_nxt;
  logic [7:0]        pendVec_r, pendVec_nxt;
  fpx_dst_s          dst_r, dst_nxt;
  fpx_exc_s          exc_r, exc_nxt;
  logic              busAct;
  logic [ST_W-1:0]   stSet;

  // zero wait state slave: hrdata is ready in the data phase that follows
  assign busAct    = hsel && htrans[HTRANS_ACT_BIT] && hready;
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;
  assign hrdata    = rdData_r;

  always_comb begin
    wrPend_nxt = busAct && hwrite;
    wrAddr_nxt = busAct ? haddr[ADDR_W-1:0] : wrAddr_r;
    rdData_nxt = WORD_ZERO;
    if (busAct && !hwrite) begin
      unique case (haddr[ADDR_W-1:0])
        OFS_STATUS: rdData_nxt[ST_W-1:0] = status_r;
        OFS_MASK:   rdData_nxt[ST_W-1:0] = mask_r;
        OFS_CTRL:   rdData_nxt[CTRL_W-1:0] = ctrl_r;
        OFS_PEND: begin
          rdData_nxt[PEND_POSTED] = (pend_r == PS_POSTED);
          rdData_nxt[PEND_VEC_HI:PEND_VEC_LO] = pendVec_r;
        end
        default:    rdData_nxt = WORD_ZERO;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= '0;
      rdData_r <= WORD_ZERO;
    end else begin
      wrPend_r <= wrPend_nxt;
      wrAddr_r <= wrAddr_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  // ----------------------------------------------------------------
  // registers: exception status byte (w1c), mask, control
  // ----------------------------------------------------------------
  always_comb begin
    status_nxt = status_r;
    mask_nxt   = mask_r;
    ctrl_nxt   = ctrl_r;
    if (wrPend_r) begin
      unique case (wrAddr_r)
        OFS_STATUS: status_nxt = status_r & ~hwdata[ST_W-1:0];
        OFS_MASK:   mask_nxt   = hwdata[ST_W-1:0];
        OFS_CTRL:   ctrl_nxt   = hwdata[CTRL_W-1:0];
        default:    status_nxt = status_r;
      endcase
    end
    status_nxt = status_nxt | stSet;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_r <= STATUS_RST;
      mask_r   <= MASK_RST;
      ctrl_r   <= CTRL_RST;
    end else begin
      status_r <= status_nxt;
      mask_r   <= mask_nxt;
      ctrl_r   <= ctrl_nxt;
    end
  end

  assign irq = |(status_r & mask_r);

  // ----------------------------------------------------------------
  // detection
  // ----------------------------------------------------------------
  logic             anyNan, intFmt, arithErr, moveIntErr, operrMask, operrNon;
  logic             ovfHit, ovflEvt, unflEvt, handlerOn;
  fpx_prec_e        prec;
  logic [EXP_W:0]   expRnd;

  assign handlerOn = ctrl_r[CTRL_OPERAND_ERROR_FLAG_EN];
  assign anyNan    = req.srcA.nan || req.srcB.nan;
  assign intFmt    = isIntFmt(req.fmt);

  always_comb begin
    arithErr = 1'b0;
    unique case (req.op)
      OP_ADD:  arithErr = req.srcA.inf && req.srcB.inf && (req.srcA.neg != req.srcB.neg);
      OP_SUB:  arithErr = req.srcA.inf && req.srcB.inf && (req.srcA.neg == req.srcB.neg);
      OP_MUL:  arithErr = (req.srcA.zero && req.srcB.inf) || (req.srcA.inf && req.srcB.zero);
      OP_DIV:  arithErr = (req.srcA.zero && req.srcB.zero) || (req.srcA.inf && req.srcB.inf);
      OP_SQRT: arithErr = req.srcA.inf || (req.srcA.neg && !req.srcA.zero);
      default: arithErr = 1'b0;
    endcase
    // nan operands belong to the signaling nan path, not here
    arithErr = arithErr && !anyNan;
  end

  // memory and integer destinations round at their own format
  assign prec   = (req.dst == DST_FPREG) ? fpx_prec_e'(ctrl_r[CTRL_PREC_HI:CTRL_PREC_LO]) : fmtPrec(req.fmt);
  // rounding carry applied before the overflow compare
  assign expRnd = {1'b0, req.expInt} + {{EXP_W{1'b0}}, req.rndCarry};

  assign moveIntErr = req.valid && (req.op == OP_MOVE) && intFmt &&
                      (req.intOvf || req.srcA.nan || req.srcA.inf || req.intMostNeg);
  // compare against the selected precision limit
  assign ovfHit     = req.valid && !arithErr && !moveIntErr && !anyNan &&
                      (expRnd >= {1'b0, precMax(prec)});
  assign ovflEvt    = ovfHit && !intFmt;
  assign operrNon   = moveIntErr || (ovfHit && intFmt);
  assign operrMask  = req.valid && arithErr;
  // underflow checked on the unrounded exponent; extended minimum never underflows
  assign unflEvt    = req.valid && !intFmt && !arithErr && !anyNan && (prec != PREC_EXT) &&
                      (req.expInt <= ((prec == PREC_SGL) ? EXP_MIN_SGL : EXP_MIN_DBL));

  always_comb begin
    stSet           = '0;
    stSet[ST_OPERAND_ERROR_FLAG] = operrMask || operrNon;
    stSet[ST_OVERFLOW_FLAG]  = ovflEvt;
    stSet[ST_UNFL]  = unflEvt;
  end

  // ----------------------------------------------------------------
  // destination control, exception posting and taking
  // ----------------------------------------------------------------
  always_comb begin
    dst_nxt       = '0;
    dst_nxt.data  = RES_ZERO;
    exc_nxt       = '0;
    exc_nxt.vector = VEC_NONE;
    pend_nxt      = pend_r;
    pendVec_nxt   = pendVec_r;
    // pending exception fires on the next fp instruction only
    if (pend_r == PS_POSTED && fpStart) begin
      exc_nxt.take   = 1'b1;
      exc_nxt.post   = 1'b0;
      exc_nxt.vector = pendVec_r;
      pend_nxt       = PS_IDLE;
    end
    if (req.valid) begin
      dst_nxt.allow = 1'b1;
      if (operrMask && !handlerOn) begin
        dst_nxt.allow = 1'b0;
        dst_nxt.qnan  = 1'b1;
        dst_nxt.data  = QNAN_EXT;
      end else if (operrMask) begin
        dst_nxt.allow = 1'b0;
        pend_nxt      = PS_POSTED;
        pendVec_nxt   = VEC_OPERAND_ERROR_FLAG;
      end else if (operrNon) begin
        // immediate post-instruction take; post wins the port over a pre take
        dst_nxt.allow  = 1'b0;
        exc_nxt.take   = 1'b1;
        exc_nxt.post   = 1'b1;
        exc_nxt.vector = VEC_OPERAND_ERROR_FLAG;
      end else if (ovflEvt && req.dst == DST_FPREG) begin
        // register untouched, reported before the next fp instruction
        dst_nxt.allow = 1'b0;
        pend_nxt      = PS_POSTED;
        pendVec_nxt   = VEC_OVERFLOW_FLAG;
      end else if (ovflEvt) begin
        // undefined store then immediate post-instruction take
        dst_nxt.allow  = 1'b0;
        dst_nxt.undef  = 1'b1;
        exc_nxt.take   = 1'b1;
        exc_nxt.post   = 1'b1;
        exc_nxt.vector = VEC_OVERFLOW_FLAG;
      end
    end
    // a same-cycle post take owns the port; keep the pre take pending
    if (pend_r == PS_POSTED && fpStart && exc_nxt.post) begin
      pend_nxt = PS_POSTED;
    end
  end

  // limitation: a post take in the same cycle as a due pre take delays the pre take by one fpStart
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dst_r     <= '0;
      exc_r     <= '0;
      pend_r    <= PS_IDLE;
      pendVec_r <= VEC_NONE;
    end else begin
      dst_r     <= dst_nxt;
      exc_r     <= exc_nxt;
      pend_r    <= pend_nxt;
      pendVec_r <= pendVec_nxt;
    end
  end

  assign dstCtl = dst_r;
  assign exc    = exc_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // a due pre take, not crowded out by a post take or a fresh posting
  sequence preDue;
    pend_r == PS_POSTED && fpStart && !(req.valid && (operrNon || ovflEvt || (operrMask && handlerOn)));
  endsequence
  sequence preTaken;
    exc.take && !exc.post && pend_r == PS_IDLE;
  endsequence
  sequence subLike;
    req.valid && req.op == OP_SUB && req.srcA.inf && req.srcB.inf && !anyNan && req.srcA.neg == req.srcB.neg;
  endsequence

  operand_error_flag_flag_a: assert property ((operrMask || operrNon) |=> status_r[ST_OPERAND_ERROR_FLAG])
    else $error("operand error did not set its flag");

  add_cancel_a: assert property ((req.valid && req.op == OP_ADD && req.srcA.inf && req.srcB.inf && !anyNan &&
                                 req.srcA.neg != req.srcB.neg) |-> operrMask)
    else $error("infinite cancellation missed");

  sub_cancel_a: assert property (subLike |-> operrMask)
    else $error("like infinity difference missed");

  zero_inf_a: assert property ((req.valid && req.op == OP_MUL && req.srcA.zero && req.srcB.inf && !anyNan)
                               |=> (status_r[ST_OPERAND_ERROR_FLAG] && !dstCtl.allow))
    else $error("zero times infinity not flagged");

  div_undef_a: assert property ((req.valid && req.op == OP_DIV && !anyNan &&
                                req.srcA.inf && req.srcB.inf) |-> operrMask)
    else $error("infinity over infinity missed");

  sqrt_neg_a: assert property ((req.valid && req.op == OP_SQRT && !anyNan &&
                               req.srcA.neg && !req.srcA.zero) |-> operrMask)
    else $error("negative root not flagged");

  qnan_fill_a: assert property ((operrMask && !handlerOn) |=> (dstCtl.qnan && dstCtl.data == QNAN_EXT &&
                                !(exc.take && exc.post)))
    else $error("quiet nan substitution wrong");

  post_hold_a: assert property ((operrMask && handlerOn) |=> (pend_r == PS_POSTED && !dstCtl.allow))
    else $error("operand error not posted");

  operand_error_flag_vec_a: assert property ((operrMask && handlerOn) |=> pendVec_r == VEC_OPERAND_ERROR_FLAG)
    else $error("posted operand error vector wrong");

  pend_stay_a: assert property ((pend_r == PS_POSTED && !fpStart) |=>
                                (pend_r == PS_POSTED && !(exc.take && !exc.post)))
    else $error("pending exception lost without fp start");

  pre_take_a: assert property (preDue |=> preTaken)
    else $error("pending exception not taken on fp start");

  move_int_a: assert property (moveIntErr |=> (exc.take && exc.post && exc.vector == VEC_OPERAND_ERROR_FLAG))
    else $error("integer move fault not taken at once");

  overflow_flag_limit_a: assert property ((req.valid && !anyNan && !arithErr && req.op != OP_MOVE && !intFmt &&
                                 prec == PREC_SGL && expRnd == {1'b0, EXP_MAX_SGL}) |-> ovflEvt)
    else $error("single precision overflow missed");

  int_fmt_a: assert property ((ovfHit && intFmt) |=> (status_r[ST_OPERAND_ERROR_FLAG] && exc.vector == VEC_OPERAND_ERROR_FLAG))
    else $error("integer format overflow not operand error");

  overflow_flag_flag_a: assert property (ovflEvt |=> status_r[ST_OVERFLOW_FLAG])
    else $error("overflow flag not set");

  overflow_flag_take_a: assert property (ovflEvt |=> (exc.take || pend_r == PS_POSTED))
    else $error("overflow neither taken nor posted");

  overflow_flag_reg_a: assert property ((ovflEvt && req.dst == DST_FPREG) |=>
                               (!dstCtl.allow && pendVec_r == VEC_OVERFLOW_FLAG))
    else $error("overflow register destination touched");

  overflow_flag_mem_a: assert property ((ovflEvt && req.dst != DST_FPREG) |=>
                               (dstCtl.undef && exc.take && exc.post))
    else $error("overflow memory store not taken");

  // an interrupt only rises after a status set or a register write
  irq_level_a: assert property ($rose(irq) |-> ($past(stSet) != '0 || $past(wrPend_r)))
    else $error("interrupt rose without cause");

endmodule // fpx_exc_unit

// [rtl/fpx_pkg.sv]
// fpx_pkg: constants, enumerations and carriers for the fp operand error / overflow exception unit
// assumes: one 100 MHz core clock, extended exponents biased by 16'h3FFF, AHB-Lite register access
package fpx_pkg;

  // ----------------------------------------------------------------
  // register map and field layout
  // ----------------------------------------------------------------
  localparam int                 ADDR_W         = 8;
  localparam logic [ADDR_W-1:0]  OFS_STATUS     = 8'h00;
  localparam logic [ADDR_W-1:0]  OFS_MASK       = 8'h04;
  localparam logic [ADDR_W-1:0]  OFS_CTRL       = 8'h08;
  localparam logic [ADDR_W-1:0]  OFS_PEND       = 8'h0C;
  localparam int                 ST_W           = 3;
  localparam int                 ST_OPERAND_ERROR_FLAG       = 0;
  localparam int                 ST_OVERFLOW_FLAG        = 1;
  localparam int                 ST_UNFL        = 2;
  localparam int                 CTRL_W         = 3;
  localparam int                 CTRL_OPERAND_ERROR_FLAG_EN  = 0;
  localparam int                 CTRL_PREC_LO   = 1;
  localparam int                 CTRL_PREC_HI   = 2;
  localparam int                 PEND_POSTED    = 0;
  localparam int                 PEND_VEC_LO    = 8;
  localparam int                 PEND_VEC_HI    = 15;
  localparam logic [ST_W-1:0]    STATUS_RST     = 3'h0;
  localparam logic [ST_W-1:0]    MASK_RST       = 3'h0;
  localparam logic [CTRL_W-1:0]  CTRL_RST       = 3'h0;
  localparam logic [31:0]        WORD_ZERO      = 32'h0000_0000;
  localparam int                 HTRANS_ACT_BIT = 1;
  localparam logic               HRESP_OKAY     = 1'b0;

  // ----------------------------------------------------------------
  // exception vectors (values arbitrary, overridable at the top)
  // ----------------------------------------------------------------
  localparam logic [7:0]         VEC_OPERAND_ERROR_FLAG_DEF  = 8'h01;
  localparam logic [7:0]         VEC_OVERFLOW_FLAG_DEF   = 8'h02;
  localparam logic [7:0]         VEC_NONE       = 8'h00;

  // ----------------------------------------------------------------
  // exponent limits, biased as extended
  // ----------------------------------------------------------------
  localparam int                 EXP_W          = 16;
  localparam logic [EXP_W-1:0]   EXP_MAX_SGL    = 16'h407F;
  localparam logic [EXP_W-1:0]   EXP_MAX_DBL    = 16'h43FF;
  localparam logic [EXP_W-1:0]   EXP_MAX_EXT    = 16'h7FFF;
  localparam logic [EXP_W-1:0]   EXP_MIN_SGL    = 16'h3F81;
  localparam logic [EXP_W-1:0]   EXP_MIN_DBL    = 16'h3C01;
  localparam int                 RES_W          = 80;
  localparam logic [RES_W-1:0]   QNAN_EXT       = 80'h7FFF_FFFF_FFFF_FFFF_FFFF;
  localparam logic [RES_W-1:0]   RES_ZERO       = 80'h0000_0000_0000_0000_0000;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PREC_EXT = 2'h0, PREC_SGL = 2'h1, PREC_DBL = 2'h2} fpx_prec_e;
  typedef enum logic [2:0] {OP_ADD = 3'h0, OP_SUB = 3'h1, OP_MUL = 3'h2, OP_DIV = 3'h3,
                            OP_SQRT = 3'h4, OP_MOVE = 3'h5} fpx_op_e;
  typedef enum logic [1:0] {DST_FPREG = 2'h0, DST_MEM = 2'h1, DST_INTREG = 2'h2} fpx_dst_e;
  typedef enum logic [2:0] {FMT_BYTE = 3'h0, FMT_WORD = 3'h1, FMT_LONG = 3'h2,
                            FMT_SGL = 3'h3, FMT_DBL = 3'h4, FMT_EXT = 3'h5} fpx_fmt_e;
  typedef enum logic [1:0] {PS_IDLE = 2'b01, PS_POSTED = 2'b10} fpx_pend_e;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic zero;
    logic inf;
    logic nan;
    logic neg;
  } fpx_cls_s;

  typedef struct packed {
    logic             valid;
    fpx_op_e          op;
    fpx_dst_e         dst;
    fpx_fmt_e         fmt;
    fpx_cls_s         srcA;
    fpx_cls_s         srcB;
    logic [EXP_W-1:0] expInt;
    logic             rndCarry;
    logic             intOvf;
    logic             intMostNeg;
  } fpx_req_s;

  typedef struct packed {
    logic       take;
    logic       post;
    logic [7:0] vector;
  } fpx_exc_s;

  typedef struct packed {
    logic             allow;
    logic             qnan;
    logic             undef;
    logic [RES_W-1:0] data;
  } fpx_dst_s;

endpackage

// [test/fp_operand_overflow_exceptions_bench.sv]
// fp_operand_overflow_exceptions_bench: self-checking bench for fpx_exc_unit
// assumes: default vectors, zero-wait slave whose hreadyout is looped to hready
`timescale 1ns/1ps

module fp_operand_overflow_exceptions_bench;
  import fpx_pkg::*;
  // ----------------------------------------------------------------
  // signals and case table
  // ----------------------------------------------------------------
  localparam logic [7:0] VO = VEC_OPERAND_ERROR_FLAG_DEF;
  localparam logic [7:0] VV = VEC_OVERFLOW_FLAG_DEF;
  // fl = {qnan, undef, take, post, pending}; io = {rndCarry, intOvf, intMostNeg}
  typedef struct packed {
    fpx_op_e     op;
    fpx_dst_e    d;
    fpx_fmt_e    f;
    logic [3:0]  a;
    logic [3:0]  b;
    logic [15:0] e;
    logic [2:0]  io;
    logic [2:0]  c;
    logic [4:0]  fl;
    logic [7:0]  vc;
    logic [2:0]  st;
  } fpx_row_s;
  logic        core_clk;
  logic        rst_b;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hready;
  logic        hresp;
  logic [31:0] hrdata;
  fpx_req_s    req;
  logic        fpStart;
  fpx_dst_s    dstCtl;
  fpx_exc_s    exc;
  logic        irq;
  logic        fpIssue;
  fpx_exc_s    lastExc;
  logic [7:0]  nTakes;
  logic [31:0] v;
  logic [7:0]  n0;
  int          n_errors;
  int          compares;
  fpx_row_s rows [22] = '{
    '{OP_ADD, DST_FPREG, FMT_EXT, 4'h4, 4'h5, 16'h3FFF, 3'h0, 3'h0, 5'h10, 8'h00, 3'h1},
    '{OP_ADD, DST_FPREG, FMT_EXT, 4'h5, 4'h4, 16'h3FFF, 3'h0, 3'h1, 5'h01, VO, 3'h1},
    '{OP_SUB, DST_FPREG, FMT_EXT, 4'h4, 4'h4, 16'h3FFF, 3'h0, 3'h0, 5'h10, 8'h00, 3'h1},
    '{OP_SUB, DST_FPREG, FMT_EXT, 4'h5, 4'h5, 16'h3FFF, 3'h0, 3'h1, 5'h01, VO, 3'h1},
    '{OP_SUB, DST_FPREG, FMT_EXT, 4'h4, 4'h5, 16'h3FFF, 3'h0, 3'h0, 5'h00, 8'h00, 3'h0},
    '{OP_MUL, DST_FPREG, FMT_EXT, 4'h8, 4'h4, 16'h3FFF, 3'h0, 3'h0, 5'h10, 8'h00, 3'h1},
    '{OP_DIV, DST_FPREG, FMT_EXT, 4'h8, 4'h8, 16'h3FFF, 3'h0, 3'h0, 5'h10, 8'h00, 3'h1},
    '{OP_DIV, DST_FPREG, FMT_EXT, 4'h4, 4'h4, 16'h3FFF, 3'h0, 3'h1, 5'h01, VO, 3'h1},
    '{OP_SQRT, DST_FPREG, FMT_EXT, 4'h1, 4'h0, 16'h3FFF, 3'h0, 3'h0, 5'h10, 8'h00, 3'h1},
    '{OP_SQRT, DST_FPREG, FMT_EXT, 4'h4, 4'h0, 16'h3FFF, 3'h0, 3'h1, 5'h01, VO, 3'h1},
    '{OP_MOVE, DST_INTREG, FMT_LONG, 4'h0, 4'h0, 16'h3FFF, 3'h2, 3'h1, 5'h06, VO, 3'h1},
    '{OP_MOVE, DST_MEM, FMT_BYTE, 4'h2, 4'h0, 16'h3FFF, 3'h0, 3'h0, 5'h06, VO, 3'h1},
    '{OP_MOVE, DST_MEM, FMT_WORD, 4'h4, 4'h0, 16'h3FFF, 3'h0, 3'h0, 5'h06, VO, 3'h1},
    '{OP_MOVE, DST_INTREG, FMT_BYTE, 4'h1, 4'h0, 16'h3FFF, 3'h1, 3'h0, 5'h06, VO, 3'h1},
    '{OP_ADD, DST_FPREG, FMT_EXT, 4'h0, 4'h0, 16'h407F, 3'h0, 3'h2, 5'h01, VV, 3'h2},
    '{OP_ADD, DST_FPREG, FMT_EXT, 4'h0, 4'h0, 16'h407E, 3'h4, 3'h2, 5'h01, VV, 3'h2},
    '{OP_ADD, DST_FPREG, FMT_EXT, 4'h0, 4'h0, 16'h407E, 3'h0, 3'h2, 5'h00, 8'h00, 3'h0},
    '{OP_MUL, DST_MEM, FMT_DBL, 4'h0, 4'h0, 16'h43FF, 3'h0, 3'h0, 5'h0E, VV, 3'h2},
    '{OP_DIV, DST_MEM, FMT_LONG, 4'h0, 4'h0, 16'h7FFF, 3'h2, 3'h0, 5'h06, VO, 3'h1},
    '{OP_SUB, DST_FPREG, FMT_EXT, 4'h0, 4'h0, 16'h43FF, 3'h0, 3'h5, 5'h01, VV, 3'h2},
    '{OP_ADD, DST_FPREG, FMT_EXT, 4'h0, 4'h0, 16'h3F81, 3'h0, 3'h2, 5'h00, 8'h00, 3'h4},
    '{OP_MOVE, DST_MEM, FMT_SGL, 4'h0, 4'h0, 16'h407F, 3'h0, 3'h0, 5'h0E, VV, 3'h2}
  };

  fpx_exc_unit dut (
    .core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .req(req), .fpStart(fpStart), .dstCtl(dstCtl), .exc(exc), .irq(irq)
  );

  fpx_pipe_model pipe (
    .core_clk(core_clk), .rst_b(rst_b), .fpIssue(fpIssue), .exc(exc), .fpStart(fpStart),
    .lastExc(lastExc), .nTakes(nTakes)
  );

  always #5 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (n_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [95:0] seen, input logic [95:0] want);
    compares++;
    if (seen !== want) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, want, seen);
    end
  endtask

  // waits for hready at a rising edge; a stuck bus ends the run
  task automatic wait_rdy();
    int k;
    k = 0;
    @(posedge core_clk);
    while (hready !== 1'b1) begin
      k++;
      if (k > 20) begin
        n_errors++;
        stop_test();
      end
      @(posedge core_clk);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic send(input fpx_row_s r);
    fpx_req_s q;
    q = '0;
    q.valid = 1'b1;
    q.op = r.op;
    q.dst = r.d;
    q.fmt = r.f;
    q.srcA = r.a;
    q.srcB = r.b;
    q.expInt = r.e;
    {q.rndCarry, q.intOvf, q.intMostNeg} = r.io;
    @(posedge core_clk);
    req <= q;
    @(posedge core_clk);
    req <= '0;
    #1;
  endtask

  // next fp instruction; waits for the vectoring side to record a take
  task automatic fpi();
    int k;
    n0 = nTakes;
    @(posedge core_clk);
    fpIssue <= 1'b1;
    @(posedge core_clk);
    fpIssue <= 1'b0;
    k = 0;
    while (nTakes === n0) begin
      k++;
      if (k > 20) begin
        n_errors++;
        stop_test();
      end
      @(posedge core_clk);
    end
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = '0;
    req = '0;
    fpIssue = 1'b0;
    n_errors = 0;
    compares = 0;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      wr(OFS_CTRL, {29'h0, rows[i].c});
      wr(OFS_STATUS, 32'h0000_0007);
      send(rows[i]);
      chk("qnan", {dstCtl.qnan, dstCtl.data}, {rows[i].fl[4], rows[i].fl[4] ? QNAN_EXT : RES_ZERO});
      if (rows[i].st[1]) chk("undef", dstCtl.undef, rows[i].fl[3]);
      chk("allow", dstCtl.allow, rows[i].fl == 5'h00);
      chk("take", {exc.take, exc.post}, rows[i].fl[2:1]);
      if (rows[i].fl[2]) chk("vector", exc.vector, rows[i].vc);
      xfer(1'b0, OFS_STATUS, '0, v);
      chk("status", v, rows[i].st);
      xfer(1'b0, OFS_PEND, '0, v);
      chk("pending", v & (rows[i].fl[0] ? 32'h0000_FFFF : 32'h1),
          rows[i].fl[0] ? {rows[i].vc, 8'h01} : 16'h0000);
      if (rows[i].fl[0]) begin
        fpi();
        chk("pre", {lastExc.take, lastExc.post, lastExc.vector}, {2'b10, rows[i].vc});
      end
    end
    // posted exception survives integer work, fires on the next fp instruction
    wr(OFS_CTRL, 32'h0000_0001);
    send(rows[1]);
    n0 = nTakes;
    repeat (6) @(posedge core_clk);
    chk("held", nTakes, n0);
    fpi();
    chk("taken", {lastExc.post, lastExc.vector}, {1'b0, VO});
    xfer(1'b0, OFS_PEND, '0, v);
    chk("cleared", v[0], 1'b0);
    // interrupt raised, masked, cleared
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_STATUS, 32'h0000_0007);
    wr(OFS_MASK, 32'h0000_0001);
    chk("irq idle", irq, 1'b0);
    send(rows[0]);
    chk("irq on", irq, 1'b1);
    wr(OFS_MASK, 32'h0000_0002);
    chk("irq masked", irq, 1'b0);
    wr(OFS_MASK, 32'h0000_0001);
    chk("irq again", irq, 1'b1);
    wr(OFS_STATUS, 32'h0000_0001);
    chk("irq clear", irq, 1'b0);
    // mid-run reset returns every register to zero; unmapped offset reads zero
    wr(OFS_CTRL, 32'h0000_0005);
    send(rows[0]);
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("rst outs", {irq, exc, dstCtl.qnan, hresp}, '0);
    rst_b <= 1'b1;
    foreach (rows[i]) if (i < 5) begin
      xfer(1'b0, 8'(4 * i), '0, v);
      chk("reset reg", v, '0);
    end
    stop_test();
  end
endmodule // fp_operand_overflow_exceptions_bench

// [test/fpx_pipe_model.sv]
// fpx_pipe_model: stand-in for the integer pipeline and exception vectoring
// assumes: bench raises fpIssue for one cycle per fp instruction, exc is a one-cycle pulse
`timescale 1ns/1ps

module fpx_pipe_model
  import fpx_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic              fpIssue,
  input  wire fpx_pkg::fpx_exc_s exc,
  output      logic              fpStart,
  output      fpx_pkg::fpx_exc_s lastExc,
  output      logic [7:0]        nTakes
);
  // ----------------------------------------------------------------
  // fp instruction start and vectoring record
  // ----------------------------------------------------------------
  // start is a pulse: one issue is exactly one fp instruction, never held over
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fpStart <= 1'b0;
      lastExc <= '0;
      nTakes  <= 8'h00;
    end else begin
      fpStart <= fpIssue;
      if (exc.take) begin
        lastExc <= exc;
        nTakes  <= nTakes + 8'h01;
      end
    end
  end
endmodule // fpx_pipe_model
